// *** design/quart_pins.sv ***
// quad uart channel select, host data bus, modem pins and interrupt outputs
// Overview of operation
// [RQ1] In 16 mode a channel is addressed only while its own active-low select is low.
// [RQ2] In 68 mode the select pins change role: channel A's select is a common enable.
// [RQ3] A low clear-to-send from the modem means it will accept transmit data.
// [RQ4] Software sees the clear-to-send level in bit 4 of the modem status register.
// [RQ5] Clear-to-send steers transmission only when auto flow control bit 7 of the feature reg is on.
// [RQ6] The host data bus is 8 bits and tri-state with bit zero the least significant.
// [RQ7] Data-set-ready is status only and never changes transmit or receive behaviour.
// [RQ8] Writing 1 to modem control bit 0 drives data-terminal-ready low.
// [RQ9] Writing 0 to that bit, or reset, returns data-terminal-ready high.
// [RQ10] Data-terminal-ready is a software-driven pin with no effect on the uart.
// [RQ11] In 16 mode each of the four channels has its own active-high interrupt output.
// [RQ12] An interrupt output rises only with modem control bit 3, an enabled source and a pending event.
// [RQ13] Sources are receive errors, receive data, transmit empty and modem status change.
// [RQ14] Modem control bit 3 turns on the interrupt output drivers, otherwise they float.
// [RQ15] Every channel keeps its own register copies so one never affects another.
`timescale 1ns/1ps
`default_nettype none
module quart_pins #(
  parameter int CHAN_N = quart_pins_pkg::CHAN_NUM,
  parameter int DATA_W = quart_pins_pkg::DATA_BITS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // bus mode, high selects 68 mode
  input wire logic mode_68,
  // channel selects
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic chan_c_select_n,
  input wire logic chan_d_select_n,
  // host bus
  input wire logic [quart_pins_pkg::ADDR_BITS-1:0] host_addr,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic [quart_pins_pkg::DATA_BITS-1:0] host_data_in,
  output logic [quart_pins_pkg::DATA_BITS-1:0] host_data_out,
  output logic host_data_oe,
  // modem pins
  input wire logic [quart_pins_pkg::CHAN_NUM-1:0] cts_n,
  input wire logic [quart_pins_pkg::CHAN_NUM-1:0] dsr_n,
  output logic [quart_pins_pkg::CHAN_NUM-1:0] dtr_n,
  // uart core
  input wire quart_pins_pkg::core_status_t [quart_pins_pkg::CHAN_NUM-1:0] core_status,
  output logic [quart_pins_pkg::CHAN_NUM-1:0] tx_permit,
  // interrupt pins
  output logic chan_a_irq_out,
  output logic chan_b_irq_out,
  output logic chan_c_irq_out,
  output logic chan_d_irq_out,
  output logic [quart_pins_pkg::CHAN_NUM-1:0] irq_oe
);
  import quart_pins_pkg::*;

  if (CHAN_N != CHAN_NUM || DATA_W != DATA_BITS) begin : g_bad_cfg
    $error("quart_pins supports exactly four channels and an 8-bit bus");
  end

  logic [CHAN_NUM-1:0] sel_n;
  logic [CHAN_NUM-1:0] chan_hit;
  logic [CHAN_FIELD_BITS-1:0] chan_idx;
  logic any_hit;
  bus_state_t state_q;
  bus_state_t state_d;
  reg_access_t acc_q;
  logic [CHAN_NUM-1:0] chan_q;
  logic [DATA_BITS-1:0] chan_rdata [CHAN_NUM];
  logic [DATA_BITS-1:0] data_out_q;
  logic data_oe_q;
  logic [CHAN_NUM-1:0] irq_q;

  assign sel_n = {chan_d_select_n, chan_c_select_n, chan_b_select_n, chan_a_select_n};

  // channel decode, per-pin in 16 mode, address field in 68 mode
  always_comb begin
    if (mode_68) begin
      if (sel_n[0]) begin
        chan_hit = '0;
      end else begin
        chan_hit = 4'h1 << host_addr[CHAN_FIELD_LSB +: CHAN_FIELD_BITS]; // see [RQ2]
      end
    end else begin
      chan_hit = ~sel_n; // see [RQ1]
    end
    any_hit = |chan_hit;
  end

  // lowest selected channel answers a read when several are low
  always_comb begin
    chan_idx = '0;
    for (int i = CHAN_NUM - 1; i >= 0; i--) begin
      if (chan_hit[i]) begin
        chan_idx = CHAN_FIELD_BITS'(i);
      end
    end
  end

  // host strobe tracking, one access per strobe
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (any_hit && !host_rd_n) begin
          state_d = ST_READ;
        end else if (any_hit && !host_wr_n) begin
          state_d = ST_WRITE;
        end
      end
      ST_READ: begin
        if (host_rd_n || !any_hit) begin
          state_d = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (host_wr_n) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // one-cycle access pulses toward the addressed channel
  always_ff @(posedge core_clk) begin
    if (reset) begin
      acc_q <= '0;
      chan_q <= '0;
    end else begin
      acc_q.wr <= (state_q == ST_IDLE) && (state_d == ST_WRITE);
      acc_q.rd <= (state_q == ST_IDLE) && (state_d == ST_READ);
      acc_q.addr <= host_addr[REG_ADDR_BITS-1:0];
      acc_q.wdata <= host_data_in; // see [RQ6]
      chan_q <= chan_hit; // see [RQ1]
    end
  end

  // read data is captured at the strobe edge and held while it stays low
  always_ff @(posedge core_clk) begin
    if (reset) begin
      data_out_q <= DATA_ZERO;
      data_oe_q <= 1'b0;
    end else begin
      if ((state_q == ST_IDLE) && (state_d == ST_READ)) begin
        data_out_q <= chan_rdata[chan_idx]; // see [RQ6]
      end
      data_oe_q <= (state_d == ST_READ); // see [RQ6]
    end
  end

  // independent register set per channel
  for (genvar g = 0; g < CHAN_NUM; g++) begin : g_chan
    quart_chan_regs u_regs (
      .core_clk(core_clk),
      .reset(reset),
      .mode_68(mode_68),
      .sel(chan_q[g]), // see [RQ15]
      .acc(acc_q),
      .rd_addr(host_addr[REG_ADDR_BITS-1:0]),
      .rdata(chan_rdata[g]),
      .cts_n(cts_n[g]),
      .dsr_n(dsr_n[g]),
      .dtr_n_q(dtr_n[g]),
      .status(core_status[g]),
      .tx_permit_q(tx_permit[g]),
      .irq_q(irq_q[g]), // see [RQ11]
      .irq_oe_q(irq_oe[g])
    );
  end

  assign host_data_out = data_out_q;
  assign host_data_oe = data_oe_q;
  assign chan_a_irq_out = irq_q[0];
  assign chan_b_irq_out = irq_q[1];
  assign chan_c_irq_out = irq_q[2];
  assign chan_d_irq_out = irq_q[3];

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  sel_only_a: assert property (acc_q.wr && !$past(mode_68) // see [RQ1]
      |-> chan_q == ~$past(sel_n))
    else $error("write reached channel without its select");
  mode68_sel_a: assert property ((state_q == ST_IDLE) && mode_68 && !chan_a_select_n // see [RQ2]
      && !host_wr_n |=> chan_q == (4'h1 << $past(host_addr[CHAN_FIELD_LSB +: CHAN_FIELD_BITS])))
    else $error("68 mode channel decode wrong");
  dtr_set_a: assert property ((state_q == ST_IDLE) && (state_d == ST_WRITE) // see [RQ8]
      && chan_hit[0] && (host_addr[REG_ADDR_BITS-1:0] == REG_MCR) && !mode_68
      |=> ##1 dtr_n[0] == !$past(host_data_in[MCR_DTR_BIT], 2))
    else $error("dtr did not follow modem control bit 0");
  dtr_reset_a: assert property ($fell(reset) |-> dtr_n == 4'hF) // see [RQ9]
    else $error("dtr not high after reset");
  read_drive_a: assert property ((state_q == ST_IDLE) && (state_d == ST_READ)
      |=> host_data_oe && host_data_out == $past(chan_rdata[chan_idx])) // see [RQ6]
    else $error("read data not driven");
  bus_float_a: assert property (host_rd_n && $past(host_rd_n) |-> !host_data_oe) // see [RQ6]
    else $error("data bus driven without read strobe");
  irq_68_a: assert property (mode_68 && $past(mode_68) // see [RQ11]
      |-> irq_q == 4'h0 && irq_oe == 4'h0)
    else $error("per-channel interrupt active in 68 mode");
  own_chan_a: assert property (acc_q.wr && chan_q == 4'h2 && acc_q.addr == REG_MCR
      |=> $stable(dtr_n[0]) && $stable(dtr_n[2])) // see [RQ15]
    else $error("write to channel b disturbed another channel");
  sel_none_a: assert property ((state_q == ST_IDLE) && !mode_68 && (&sel_n) // see [RQ1]
      |=> !acc_q.wr && !acc_q.rd)
    else $error("access taken with no channel selected");
  mode68_off_a: assert property ((state_q == ST_IDLE) && mode_68 && chan_a_select_n // see [RQ2]
      |=> !acc_q.wr && !acc_q.rd)
    else $error("68 mode access without common enable");
  mode68_hit_a: assert property (mode_68 |-> $onehot0(chan_hit)) // see [RQ2]
    else $error("68 mode selected several channels");
  one_write_a: assert property (acc_q.wr |=> !acc_q.wr) // see [RQ6]
    else $error("held write strobe gave two accesses");
  one_read_a: assert property (acc_q.rd |=> !acc_q.rd) // see [RQ6]
    else $error("held read strobe gave two accesses");
  write_data_a: assert property (acc_q.wr |-> acc_q.wdata == $past(host_data_in)) // see [RQ6]
    else $error("write data not taken from the bus");
  data_hold_a: assert property (host_data_oe && $past(host_data_oe) // see [RQ6]
      |-> $stable(host_data_out))
    else $error("read data moved while driven");
  oe_release_a: assert property ((state_q == ST_READ) && host_rd_n // see [RQ6]
      |=> !host_data_oe)
    else $error("data bus still driven after read strobe released");

  // per-channel pin checks
  for (genvar g = 0; g < CHAN_NUM; g++) begin : g_pin_chk
    dtr_write_a: assert property (@(posedge core_clk) disable iff (reset) // see [RQ8]
        acc_q.wr && chan_q[g] && (acc_q.addr == REG_MCR)
        |=> dtr_n[g] == !$past(acc_q.wdata[MCR_DTR_BIT]))
      else $error("dtr did not follow its modem control write");
    dtr_hold_a: assert property (@(posedge core_clk) disable iff (reset) // see [RQ10]
        !(acc_q.wr && chan_q[g] && (acc_q.addr == REG_MCR))
        |=> $stable(dtr_n[g]))
      else $error("dtr moved without a modem control write");
    irq_float_a: assert property (@(posedge core_clk) disable iff (reset) // see [RQ14]
        !irq_oe[g] |-> !irq_q[g])
      else $error("interrupt output high while its driver is off");
    dsr_free_a: assert property (@(posedge core_clk) disable iff (reset) // see [RQ7]
        $stable(cts_n[g]) && !$past(acc_q.wr && chan_q[g])
        |=> $stable(tx_permit[g]))
      else $error("transmit permission moved without cts or feature change");
  end

  write_c: cover property ((state_q == ST_IDLE) && (state_d == ST_WRITE));
  read_c: cover property (host_data_oe [*2]);
  irq_c: cover property (chan_a_irq_out && chan_d_irq_out);
  flow_c: cover property ($fell(tx_permit[1]));
endmodule
`default_nettype wire

// *** design/quart_pins_pkg.sv ***
// constants and carrier types for the quad uart pin and modem-control block
package quart_pins_pkg;
  localparam int CHAN_NUM = 4;
  localparam int DATA_BITS = 8;
  localparam int ADDR_BITS = 5;
  localparam int REG_ADDR_BITS = 3;
  localparam int CHAN_FIELD_LSB = 3;
  localparam int CHAN_FIELD_BITS = 2;
  localparam logic [2:0] REG_IER = 3'h1;
  localparam logic [2:0] REG_EFR_ISR = 3'h2;
  localparam logic [2:0] REG_MCR = 3'h4;
  localparam logic [2:0] REG_MSR = 3'h6;
  localparam int MCR_DTR_BIT = 0;
  localparam int MCR_IRQ_EN_BIT = 3;
  localparam int MSR_DCTS_BIT = 0;
  localparam int MSR_DDSR_BIT = 1;
  localparam int MSR_CTS_BIT = 4;
  localparam int MSR_DSR_BIT = 5;
  localparam int EFR_AUTO_CTS_BIT = 7;
  localparam int IER_RX_AVAIL_BIT = 0;
  localparam int IER_TX_EMPTY_BIT = 1;
  localparam int IER_RX_ERR_BIT = 2;
  localparam int IER_MODEM_BIT = 3;
  localparam int ISR_RX_ERR_BIT = 0;
  localparam int ISR_RX_AVAIL_BIT = 1;
  localparam int ISR_TX_EMPTY_BIT = 2;
  localparam int ISR_MODEM_BIT = 3;
  localparam logic [7:0] MCR_RESET = 8'h00;
  localparam logic [7:0] IER_RESET = 8'h00;
  localparam logic [7:0] EFR_RESET = 8'h00;
  localparam logic [7:0] DATA_ZERO = 8'h00;

  typedef struct packed {
    logic rx_error;
    logic rx_ready;
    logic tx_empty;
  } core_status_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [REG_ADDR_BITS-1:0] addr;
    logic [DATA_BITS-1:0] wdata;
  } reg_access_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } bus_state_t;
endpackage

// *** design/quart_chan_regs.sv ***
// per-channel modem control, modem status, interrupt enable and feature state
`timescale 1ns/1ps
`default_nettype none
module quart_chan_regs (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // bus mode
  input wire logic mode_68,
  // register access
  input wire logic sel,
  input wire quart_pins_pkg::reg_access_t acc,
  input wire logic [quart_pins_pkg::REG_ADDR_BITS-1:0] rd_addr,
  output logic [quart_pins_pkg::DATA_BITS-1:0] rdata,
  // modem pins
  input wire logic cts_n,
  input wire logic dsr_n,
  output logic dtr_n_q,
  // uart core
  input wire quart_pins_pkg::core_status_t status,
  output logic tx_permit_q,
  // interrupt pin
  output logic irq_q,
  output logic irq_oe_q
);
  import quart_pins_pkg::*;

  logic [7:0] mcr_q;
  logic [7:0] ier_q;
  logic [7:0] efr_q;
  logic cts_prev_q;
  logic dsr_prev_q;
  logic dcts_q;
  logic ddsr_q;
  logic [7:0] modem_status_reg;
  logic [7:0] isr;
  logic pend;
  logic wr_hit;
  logic msr_rd;

  assign wr_hit = sel && acc.wr;
  assign msr_rd = sel && acc.rd && (acc.addr == REG_MSR);

  // control registers, dtr follows its bit directly
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mcr_q <= MCR_RESET;
      ier_q <= IER_RESET;
      efr_q <= EFR_RESET;
      dtr_n_q <= 1'b1; // see [RQ9]
    end else if (wr_hit) begin
      if (acc.addr == REG_MCR) begin
        mcr_q <= acc.wdata;
        dtr_n_q <= ~acc.wdata[MCR_DTR_BIT]; // see [RQ8] see [RQ9] see [RQ10]
      end
      if (acc.addr == REG_IER) begin
        ier_q <= acc.wdata;
      end
      if (acc.addr == REG_EFR_ISR) begin
        efr_q <= acc.wdata;
      end
    end
  end

  // modem status deltas, a new change wins over a clearing read
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cts_prev_q <= 1'b1;
      dsr_prev_q <= 1'b1;
      dcts_q <= 1'b0;
      ddsr_q <= 1'b0;
    end else begin
      cts_prev_q <= cts_n;
      dsr_prev_q <= dsr_n;
      if (cts_n != cts_prev_q) begin
        dcts_q <= 1'b1;
      end else if (msr_rd) begin
        dcts_q <= 1'b0;
      end
      if (dsr_n != dsr_prev_q) begin
        ddsr_q <= 1'b1;
      end else if (msr_rd) begin
        ddsr_q <= 1'b0;
      end
    end
  end

  always_comb begin
    modem_status_reg = DATA_ZERO;
    modem_status_reg[MSR_CTS_BIT] = ~cts_n; // see [RQ4] see [RQ3]
    modem_status_reg[MSR_DSR_BIT] = ~dsr_n; // see [RQ7]
    modem_status_reg[MSR_DCTS_BIT] = dcts_q;
    modem_status_reg[MSR_DDSR_BIT] = ddsr_q;
  end

  // pending sources gated by their enables
  always_comb begin
    isr = DATA_ZERO;
    isr[ISR_RX_ERR_BIT] = status.rx_error && ier_q[IER_RX_ERR_BIT]; // see [RQ13]
    isr[ISR_RX_AVAIL_BIT] = status.rx_ready && ier_q[IER_RX_AVAIL_BIT];
    isr[ISR_TX_EMPTY_BIT] = status.tx_empty && ier_q[IER_TX_EMPTY_BIT];
    isr[ISR_MODEM_BIT] = (dcts_q || ddsr_q) && ier_q[IER_MODEM_BIT];
    pend = |isr;
  end

  always_comb begin
    case (rd_addr)
      REG_IER: rdata = ier_q;
      REG_EFR_ISR: rdata = isr;
      REG_MCR: rdata = mcr_q;
      REG_MSR: rdata = modem_status_reg;
      default: rdata = DATA_ZERO;
    endcase
  end

  // interrupt pin and its driver enable
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_q <= 1'b0;
      irq_oe_q <= 1'b0;
    end else begin
      irq_q <= mcr_q[MCR_IRQ_EN_BIT] && pend && !mode_68; // see [RQ12]
      irq_oe_q <= mcr_q[MCR_IRQ_EN_BIT] && !mode_68; // see [RQ14] see [RQ2]
    end
  end

  // transmit permission, cts only counts with auto flow control on
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_permit_q <= 1'b1;
    end else begin
      tx_permit_q <= !efr_q[EFR_AUTO_CTS_BIT] || !cts_n; // see [RQ5] see [RQ3]
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  irq_gated_a: assert property (irq_q |-> $past(mcr_q[MCR_IRQ_EN_BIT] && pend)) // see [RQ12]
    else $error("irq raised without enable and pending source");
  irq_drive_a: assert property (!irq_oe_q |-> !irq_q) // see [RQ14]
    else $error("irq high while driver disabled");
  cts_flow_a: assert property (!efr_q[EFR_AUTO_CTS_BIT] && !$past(efr_q[EFR_AUTO_CTS_BIT])
      |=> tx_permit_q) // see [RQ5]
    else $error("cts stalled transmit without auto flow control");
  cts_stall_a: assert property (efr_q[EFR_AUTO_CTS_BIT] && cts_n |=> !tx_permit_q) // see [RQ5]
    else $error("transmit permitted while cts high under auto flow control");
  dsr_inert_a: assert property ($changed(dsr_n) && !efr_q[EFR_AUTO_CTS_BIT] ##1 1
      |-> tx_permit_q) // see [RQ7]
    else $error("dsr affected transmit permission");
  delta_set_a: assert property ($changed(cts_n) // see [RQ13]
      |=> dcts_q[*2] or (dcts_q ##1 !dcts_q))
    else $error("cts change not flagged");
  modem_irq_c: cover property (dcts_q && ier_q[IER_MODEM_BIT] ##1 irq_q);
endmodule
`default_nettype wire

// *** bench/modem_model.sv ***
// modem side model driving clear-to-send and data-set-ready per channel
`timescale 1ns/1ps
`default_nettype none
module modem_model (
  // clock
  input wire logic core_clk,
  // commanded state, high means asserted
  input wire logic [3:0] ready_set,
  input wire logic [3:0] power_set,
  // modem pins
  output logic [3:0] cts_n,
  output logic [3:0] dsr_n
);
  // pins move only on the falling edge, away from sampling
  always @(negedge core_clk) begin
    cts_n <= ~ready_set;
    dsr_n <= ~power_set;
  end
endmodule
`default_nettype wire

// *** bench/quart_pins_tb.sv ***
// self-checking bench for the quad uart pin block
`timescale 1ns/1ps
`default_nettype none
module quart_pins_tb;
  import quart_pins_pkg::*;
  logic core_clk, reset, mode_68, rd_n, wr_n;
  logic [3:0] sel_n, rdy, pwr;
  logic [4:0] addr;
  logic [7:0] wd, rv;
  core_status_t [3:0] cs;
  wire [3:0] cts_n, dsr_n, dtr_n, tx_permit, irq_oe, irqv;
  wire [7:0] dout;
  wire oe;
  int n_fail, checks_done, cycles;

  quart_pins i_dut (.core_clk(core_clk), .reset(reset), .mode_68(mode_68),
    .chan_a_select_n(sel_n[0]), .chan_b_select_n(sel_n[1]),
    .chan_c_select_n(sel_n[2]), .chan_d_select_n(sel_n[3]),
    .host_addr(addr), .host_rd_n(rd_n), .host_wr_n(wr_n), .host_data_in(wd),
    .host_data_out(dout), .host_data_oe(oe), .cts_n(cts_n), .dsr_n(dsr_n),
    .dtr_n(dtr_n), .core_status(cs), .tx_permit(tx_permit),
    .chan_a_irq_out(irqv[0]), .chan_b_irq_out(irqv[1]),
    .chan_c_irq_out(irqv[2]), .chan_d_irq_out(irqv[3]), .irq_oe(irq_oe));
  modem_model i_modem (.core_clk(core_clk), .ready_set(rdy), .power_set(pwr),
    .cts_n(cts_n), .dsr_n(dsr_n));

  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      final_report;
    end
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [3:0] bit_of(input int c);
    return 4'h1 << c;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // one host access, strobe held for one cycle on a read and two on a write, then released
  task automatic bus(input logic rd, input logic [3:0] sn, input int ch,
                     input logic [2:0] ra, input logic [7:0] d);
    @(negedge core_clk);
    sel_n = sn;
    addr = {ch[1:0], ra};
    wd = d;
    rd_n = !rd;
    wr_n = rd;
    @(posedge core_clk);
    if (!rd) @(posedge core_clk);
    @(negedge core_clk);
    rv = dout;
    if (rd) chk("data_oe on", oe, 1'b1);
    rd_n = 1;
    wr_n = 1;
    sel_n = 4'hF;
    @(negedge core_clk);
    chk("data_oe off", oe, 1'b0);
  endtask

  task automatic wr(input int ch, input logic [2:0] ra, input logic [7:0] d);
    bus(0, mode_68 ? 4'hE : ~bit_of(ch), ch, ra, d);
  endtask

  task automatic rd(input int ch, input logic [2:0] ra);
    bus(1, mode_68 ? 4'hE : ~bit_of(ch), ch, ra, 8'h00);
  endtask

  task automatic t_reset;
    chk("dtr_n", dtr_n, 4'hF);
    chk("irq_oe", irq_oe, 4'h0);
    chk("irq", irqv, 4'h0);
    chk("tx_permit", tx_permit, 4'hF);
    $display("test reset done");
  endtask

  task automatic t_dtr;
    for (int c = 0; c < 4; c++) begin
      wr(c, REG_MCR, 8'h01);
      chk("dtr_n low", {4'h0, dtr_n}, {4'h0, ~bit_of(c)});
      chk("tx_permit", tx_permit, 4'hF);
      wr(c, REG_MCR, 8'h00);
      chk("dtr_n high", dtr_n, 4'hF);
    end
    $display("test dtr done");
  endtask

  task automatic t_cts;
    rd(1, REG_MSR);
    rdy = 4'h2;
    cyc(3);
    rd(1, REG_MSR);
    chk("cts level and delta", rv & 8'h11, 8'h11);
    rd(1, REG_MSR);
    chk("delta cleared", rv & 8'h11, 8'h10);
    wr(1, REG_EFR_ISR, 8'h80);
    rdy = 4'h0;
    cyc(3);
    chk("permit held", tx_permit, 4'hD);
    pwr = 4'h2;
    cyc(3);
    chk("dsr no effect", tx_permit, 4'hD);
    rd(1, REG_MSR);
    chk("dsr level", rv & 8'h20, 8'h20);
    rdy = 4'h2;
    cyc(3);
    chk("permit given", tx_permit, 4'hF);
    wr(1, REG_EFR_ISR, 8'h00);
    rdy = 4'h0;
    cyc(3);
    chk("status only", tx_permit, 4'hF);
    rd(1, REG_MSR);
    $display("test cts done");
  endtask

  task automatic t_irq;
    logic [7:0] ie [3] = '{8'h04, 8'h01, 8'h02};
    wr(2, REG_MCR, 8'h08);
    chk("irq_oe", irq_oe, 4'h4);
    for (int s = 0; s < 3; s++) begin
      cs[2] = 3'b100 >> s;
      cyc(2);
      chk("irq not enabled", irqv, 4'h0);
      wr(2, REG_IER, ie[s]);
      cyc(1);
      chk("irq raised", irqv, 4'h4);
      wr(2, REG_IER, 8'h00);
      cyc(1);
      chk("irq dropped", irqv, 4'h0);
      cs[2] = 3'b000;
    end
    rd(2, REG_MSR);
    wr(2, REG_IER, 8'h08);
    rdy = 4'h4;
    cyc(3);
    chk("modem irq", irqv, 4'h4);
    rd(2, REG_MSR);
    cyc(1);
    chk("modem irq cleared", irqv, 4'h0);
    wr(2, REG_IER, 8'h02);
    cs[2] = 3'b001;
    cs[0] = 3'b111;
    cs[3] = 3'b111;
    cyc(2);
    chk("own channel only", irqv, 4'h4);
    cs[0] = 3'b000;
    cs[3] = 3'b000;
    $display("test irq done");
  endtask

  task automatic t_68;
    mode_68 = 1;
    cyc(2);
    chk("irq in 68", irqv, 4'h0);
    chk("irq_oe in 68", irq_oe, 4'h0);
    wr(3, REG_MCR, 8'h01);
    chk("dtr via addr", dtr_n, 4'h7);
    bus(0, 4'h1, 1, REG_MCR, 8'h01);
    chk("other selects ignored", dtr_n, 4'h7);
    wr(3, REG_MCR, 8'h00);
    mode_68 = 0;
    cyc(2);
    chk("irq back", irqv, 4'h4);
    bus(0, 4'hF, 1, REG_MCR, 8'h01);
    chk("no select", dtr_n, 4'hF);
    wr(2, REG_MCR, 8'h00);
    cyc(1);
    chk("irq gated", irqv, 4'h0);
    chk("irq_oe off", irq_oe, 4'h0);
    cs[2] = 3'b000;
    $display("test mode done");
  endtask

  task automatic t_data;
    wr(0, REG_IER, 8'h09);
    rd(0, REG_IER);
    chk("bus bit order", rv, 8'h09);
    rd(3, REG_IER);
    chk("own copy", rv, 8'h00);
    rd(0, 3'h7);
    chk("unmapped", rv, 8'h00);
    wr(0, REG_IER, 8'h00);
    $display("test data done");
  endtask

  initial begin
    reset = 1;
    mode_68 = 0;
    rd_n = 1;
    wr_n = 1;
    sel_n = 4'hF;
    addr = '0;
    wd = '0;
    rdy = '0;
    pwr = '0;
    cs = '0;
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    repeat (10) @(negedge core_clk);
    reset = 0;
    t_reset;
    t_dtr;
    t_cts;
    t_irq;
    t_68;
    t_data;
    final_report;
  end
endmodule
`default_nettype wire
